//--- shared/addr_port_pkg.sv
// Package: constants, enums and carriers of the host address bus port
package addr_port_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int ADDR_W      = 16;
    localparam int LOW_ADDR_W  = 12;
    localparam int WB_ADDR_W   = 8;
    localparam int WB_DATA_W   = 32;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [WB_ADDR_W-1:0] OFS_CONTROL   = 8'h00;
    localparam logic [WB_ADDR_W-1:0] OFS_STATUS    = 8'h04;
    localparam logic [WB_ADDR_W-1:0] OFS_HOST_ADDR = 8'h08;
    localparam logic [WB_ADDR_W-1:0] OFS_EXT_ADDR  = 8'h0C;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTL_TRANSPARENT = 0;
    localparam int CTL_EXT_ENABLE  = 1;
    localparam int ST_STRAP        = 0;
    localparam int ST_CLK_SEL_LO   = 1;
    localparam int ST_BOOT_LO      = 3;
    localparam int ST_LARGE_MEM    = 5;
    localparam int ST_DRIVING      = 6;
    localparam int ST_RT_BUSY      = 7;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [1:0]        CONTROL_RESET = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET    = 16'h0000;

    // Upper address pins and the alternate-function bits
    localparam int PIN_CLK_SEL_HI = 15;
    localparam int PIN_CLK_SEL_LO = 14;
    localparam int PIN_TIED_HIGH  = 13;
    localparam int PIN_BOOT_SEL   = 12;

    // Bits A12..A0 drive on the small part with strap low
    localparam logic [ADDR_W-1:0] SMALL_DRIVE_MASK = 16'h1FFF;
    localparam logic [ADDR_W-1:0] LOW_DECODE_MASK  = 16'h0FFF;
    localparam logic [ADDR_W-1:0] FULL_MASK        = 16'hFFFF;

    // ----------------------------------------------------------------
    // Enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CLK_10MHZ = 2'b00,
        CLK_20MHZ = 2'b01,
        CLK_12MHZ = 2'b10,
        CLK_16MHZ = 2'b11
    } clk_freq_e;

    typedef enum logic [1:0] {
        BOOT_RT_BUSY = 2'b00,
        BOOT_IDLE    = 2'b01,
        BOOT_BC      = 2'b10,
        BOOT_NONE    = 2'b11
    } boot_mode_e;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic             strap;
        logic [1:0]       clk_sel;
        logic             boot_sel;
    } strap_s;

    typedef struct packed {
        logic [ADDR_W-1:0] o;
        logic [ADDR_W-1:0] oe;
    } pin_drive_s;

endpackage

//--- hw/strap_capture.sv
// Module: one-shot capture of static straps after reset release
`timescale 1ns/1ps

module strap_capture #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Level to capture
    input  wire logic [WIDTH-1:0] level_in,
    // Captured copy
    output logic      [WIDTH-1:0] level_out,
    output logic                  valid
);

    typedef struct packed {
        logic             done;
        logic [WIDTH-1:0] val;
    } cap_s;

    cap_s st_q;
    cap_s st_d;

    // ----------------------------------------------------------------
    // Capture once, at the first edge after release
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (!st_q.done) begin
            st_d.done = 1'b1;
            st_d.val  = level_in;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.val;
    assign valid     = st_q.done;

endmodule // strap_capture

//--- hw/host_address_bus_port.sv
// Module: host address bus port with strap decode and transparent-mode drive
//
// Behaviour
// - Large-memory part: A15..A12 are always plain address lines.
// - Small part with strap high: A15..A12 are address lines too.
// - Small part, strap low: A15,A14 pick 10, 20, 12, 16 MHz.
// - Strap low, A12 zero: start in RT mode with Busy bit set.
// - Boot select one: Idle for RT-only, BC for full-function part.
// - Decode A11..A0 on small parts, A15..A0 on large parts.
// - Buffered mode never drives the address lines.
// - Transparent mode: inputs for host, outputs for external RAM cycles.
// - Drive only with grant acknowledge low and access strobe high.
// - Lines float as inputs by default, also right after reset.
`timescale 1ns/1ps

module host_address_bus_port #(
    parameter bit LARGE_MEMORY = 1'b0,
    parameter bit BC_CAPABLE   = 1'b1
) (
    // Clock and reset
    input  wire logic                                  MCLK,
    input  wire logic                                  RST,
    // Address pins
    input  wire logic [addr_port_pkg::ADDR_W-1:0]      ADDR_I,
    output logic      [addr_port_pkg::ADDR_W-1:0]      ADDR_O,
    output logic      [addr_port_pkg::ADDR_W-1:0]      ADDR_OE,
    // Configuration strap
    input  wire logic                                  UPPER_ADDRESS_STRAP,
    // Internal memory-management side
    input  wire logic                                  BUS_GRANT_ACKNOWLEDGE_N,
    input  wire logic                                  IO_ACCESS_STROBE_N,
    input  wire logic [addr_port_pkg::ADDR_W-1:0]      EXT_RAM_ADDR,
    // Decoded configuration and host address
    output logic      [addr_port_pkg::ADDR_W-1:0]      HOST_ADDR,
    output logic      [1:0]                            CLK_FREQ_SEL,
    output logic      [1:0]                            BOOT_MODE,
    output logic                                       RT_BUSY_INIT,
    output logic                                       CONFIG_VALID,
    // Wishbone slave
    input  wire logic                                  WB_CYC_I,
    input  wire logic                                  WB_STB_I,
    input  wire logic                                  WB_WE_I,
    input  wire logic [addr_port_pkg::WB_ADDR_W-1:0]   WB_ADR_I,
    input  wire logic [3:0]                            WB_SEL_I,
    input  wire logic [addr_port_pkg::WB_DATA_W-1:0]   WB_DAT_I,
    output logic      [addr_port_pkg::WB_DATA_W-1:0]   WB_DAT_O,
    output logic                                       WB_ACK_O
);

    localparam int AW = addr_port_pkg::ADDR_W;
    localparam int DW = addr_port_pkg::WB_DATA_W;

    typedef struct packed {
        logic                 transparent;
        logic                 ext_enable;
        logic [AW-1:0]        host_addr;
        logic [AW-1:0]        pin_o;
        logic [AW-1:0]        pin_oe;
        logic [1:0]           clk_sel;
        logic [1:0]           boot;
        logic                 rt_busy;
        logic                 ack;
        logic [DW-1:0]        rdata;
    } state_s;

    state_s st_q;
    state_s st_d;

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    addr_port_pkg::strap_s strap_raw;
    addr_port_pkg::strap_s strap_cap;
    logic                  strap_valid;

    // Only the pins on alternate duty matter; A13 is tied high outside
    assign strap_raw.strap    = UPPER_ADDRESS_STRAP;
    assign strap_raw.clk_sel  = {ADDR_I[addr_port_pkg::PIN_CLK_SEL_HI],
                                 ADDR_I[addr_port_pkg::PIN_CLK_SEL_LO]};
    assign strap_raw.boot_sel = ADDR_I[addr_port_pkg::PIN_BOOT_SEL];

    strap_capture #(
        .WIDTH     ($bits(addr_port_pkg::strap_s))
    ) u_strap (
        .clk       (MCLK),
        .rst       (RST),
        .level_in  (strap_raw),
        .level_out (strap_cap),
        .valid     (strap_valid)
    );

    // ----------------------------------------------------------------
    // Pin mode decode
    // ----------------------------------------------------------------
    logic          alt_upper;
    logic [AW-1:0] decode_mask;
    logic [AW-1:0] drive_mask;
    logic          drive_now;
    logic          wb_req;
    logic          wb_wr;

    // Large parts ignore the strap, except for the status strap bit
    assign alt_upper = !LARGE_MEMORY && strap_valid && !strap_cap.strap;

    // Small parts never decode A15..A12, even with the strap high
    assign decode_mask = LARGE_MEMORY ? addr_port_pkg::FULL_MASK
                                      : addr_port_pkg::LOW_DECODE_MASK;

    // Upper pins carrying straps must never be driven against them; the mask keeps A15..A13 off but still drives A12
    assign drive_mask = alt_upper ? addr_port_pkg::SMALL_DRIVE_MASK
                                  : addr_port_pkg::FULL_MASK;

    // Buffered mode (transparent clear) keeps all lines as inputs
    assign drive_now = st_q.transparent && st_q.ext_enable
                    && !BUS_GRANT_ACKNOWLEDGE_N
                    && IO_ACCESS_STROBE_N;

    assign wb_req = WB_CYC_I && WB_STB_I && !st_q.ack;
    assign wb_wr  = wb_req && WB_WE_I;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;

        // Host address is sampled only while the lines are inputs
        if (!drive_now) begin
            st_d.host_addr = ADDR_I & decode_mask;
        end

        // External RAM address always follows the mask; enables low by default
        st_d.pin_o  = EXT_RAM_ADDR & drive_mask;
        st_d.pin_oe = drive_now ? drive_mask : '0;

        // Configuration from captured straps
        if (alt_upper) begin
            st_d.clk_sel = strap_cap.clk_sel;
            if (!strap_cap.boot_sel) begin
                st_d.boot    = addr_port_pkg::BOOT_RT_BUSY;
                st_d.rt_busy = 1'b1;
            end else begin
                st_d.boot    = BC_CAPABLE ? addr_port_pkg::BOOT_BC
                                          : addr_port_pkg::BOOT_IDLE;
                st_d.rt_busy = 1'b0;
            end
        end else begin
            st_d.clk_sel = addr_port_pkg::CLK_10MHZ;
            st_d.boot    = addr_port_pkg::BOOT_NONE;
            st_d.rt_busy = 1'b0;
        end

        // Bus slave: ack one cycle after request, drop the next cycle
        st_d.ack = wb_req;
        if (wb_wr && WB_SEL_I[0] && (WB_ADR_I == addr_port_pkg::OFS_CONTROL)) begin
            st_d.transparent = WB_DAT_I[addr_port_pkg::CTL_TRANSPARENT];
            st_d.ext_enable  = WB_DAT_I[addr_port_pkg::CTL_EXT_ENABLE];
        end

        st_d.rdata = '0;
        if (wb_req && !WB_WE_I) begin
            case (WB_ADR_I)
                addr_port_pkg::OFS_CONTROL: begin
                    st_d.rdata[addr_port_pkg::CTL_TRANSPARENT] = st_q.transparent;
                    st_d.rdata[addr_port_pkg::CTL_EXT_ENABLE]  = st_q.ext_enable;
                end
                addr_port_pkg::OFS_STATUS: begin
                    st_d.rdata[addr_port_pkg::ST_STRAP]      = strap_cap.strap;
                    st_d.rdata[addr_port_pkg::ST_CLK_SEL_LO +: 2] = st_q.clk_sel;
                    st_d.rdata[addr_port_pkg::ST_BOOT_LO +: 2]    = st_q.boot;
                    st_d.rdata[addr_port_pkg::ST_LARGE_MEM]  = LARGE_MEMORY;
                    st_d.rdata[addr_port_pkg::ST_DRIVING]    = |st_q.pin_oe;
                    st_d.rdata[addr_port_pkg::ST_RT_BUSY]    = st_q.rt_busy;
                end
                addr_port_pkg::OFS_HOST_ADDR: begin
                    st_d.rdata[AW-1:0] = st_q.host_addr;
                end
                addr_port_pkg::OFS_EXT_ADDR: begin
                    st_d.rdata[AW-1:0] = st_q.pin_o;
                end
                default: begin
                    // Unmapped offsets answer with zero
                    st_d.rdata = '0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (RST) begin
            st_q             <= '0;
            st_q.transparent <= addr_port_pkg::CONTROL_RESET[addr_port_pkg::CTL_TRANSPARENT];
            st_q.ext_enable  <= addr_port_pkg::CONTROL_RESET[addr_port_pkg::CTL_EXT_ENABLE];
            st_q.host_addr   <= addr_port_pkg::ADDR_RESET;
            st_q.pin_oe      <= '0;
            st_q.boot        <= addr_port_pkg::BOOT_NONE;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Registered enable trails the grant by one cycle; the grant owner
    // must hold the cycle one extra clock to see the address settle
    assign ADDR_O       = st_q.pin_o;
    assign ADDR_OE      = st_q.pin_oe;
    assign HOST_ADDR    = st_q.host_addr;
    assign CLK_FREQ_SEL = st_q.clk_sel;
    assign BOOT_MODE    = st_q.boot;
    assign RT_BUSY_INIT = st_q.rt_busy;
    assign CONFIG_VALID = strap_valid;
    assign WB_DAT_O     = st_q.rdata;
    assign WB_ACK_O     = st_q.ack;

endmodule // host_address_bus_port

//--- bench/addr_port_chk.sv
// Checker: concurrent assertions on the host address bus port pins
`timescale 1ns/1ps

module addr_port_chk #(
    parameter bit LARGE_MEMORY = 1'b0
) (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RST,
    // Address pins and memory side
    input wire logic [15:0] ADDR_I,
    input wire logic [15:0] ADDR_O,
    input wire logic [15:0] ADDR_OE,
    input wire logic        BUS_GRANT_ACKNOWLEDGE_N,
    input wire logic        IO_ACCESS_STROBE_N,
    input wire logic [15:0] EXT_RAM_ADDR,
    // Decoded outputs
    input wire logic [15:0] HOST_ADDR,
    input wire logic [1:0]  CLK_FREQ_SEL,
    input wire logic [1:0]  BOOT_MODE,
    input wire logic        RT_BUSY_INIT,
    input wire logic        CONFIG_VALID,
    // Wishbone
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_ACK_O
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);

    localparam logic [15:0] DEC_MASK = LARGE_MEMORY ? 16'hFFFF : 16'h0FFF;
    wire own_bus = !BUS_GRANT_ACKNOWLEDGE_N && IO_ACCESS_STROBE_N;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_float_reset: assert property ($past(RST) |-> ADDR_OE == 16'h0000)
        else $error("address lines driven right after reset");
    a_drive_gate: assert property (!own_bus |=> ADDR_OE == 16'h0000)
        else $error("address lines driven without bus ownership");
    a_drive_value: assert property (ADDR_OE != 16'h0000
        |-> ADDR_O == ($past(EXT_RAM_ADDR) & ADDR_OE))
        else $error("driven address differs from memory address");
    a_alt_pins_float: assert property (BOOT_MODE != 2'b11 |-> ADDR_OE[15:13] == 3'b000)
        else $error("alternate function pins driven");
    a_host_decode: assert property (ADDR_OE == 16'h0000 && !$past(RST)
        |-> HOST_ADDR == ($past(ADDR_I) & DEC_MASK))
        else $error("host address decode wrong");
    a_boot_busy: assert property (RT_BUSY_INIT == (BOOT_MODE == 2'b00))
        else $error("busy start flag disagrees with boot mode");
    a_cfg_static: assert property ($past(CONFIG_VALID, 2) |-> $stable(CLK_FREQ_SEL) && $stable(BOOT_MODE))
        else $error("configuration changed in operation");
    a_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered next cycle");

    c_drive: cover property (ADDR_OE != 16'h0000);
    c_busy: cover property (RT_BUSY_INIT);
    c_ack: cover property (WB_ACK_O);
endmodule // addr_port_chk

bind host_address_bus_port addr_port_chk #(.LARGE_MEMORY(LARGE_MEMORY)) i_chk (
    .MCLK(MCLK), .RST(RST), .ADDR_I(ADDR_I), .ADDR_O(ADDR_O), .ADDR_OE(ADDR_OE),
    .BUS_GRANT_ACKNOWLEDGE_N(BUS_GRANT_ACKNOWLEDGE_N), .IO_ACCESS_STROBE_N(IO_ACCESS_STROBE_N),
    .EXT_RAM_ADDR(EXT_RAM_ADDR), .HOST_ADDR(HOST_ADDR), .CLK_FREQ_SEL(CLK_FREQ_SEL),
    .BOOT_MODE(BOOT_MODE), .RT_BUSY_INIT(RT_BUSY_INIT), .CONFIG_VALID(CONFIG_VALID),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O)
);

//--- bench/ext_side_model.sv
// Model: host address drivers, pin tie-off and resolved address pin levels
`timescale 1ns/1ps

module ext_side_model (
    // Host side levels
    input wire logic [15:0] host_addr,
    input wire logic        strap,
    // Device drive
    input wire logic [15:0] dev_o,
    input wire logic [15:0] dev_oe,
    // Resolved pins
    output logic     [15:0] pins
);
    always_comb begin
        for (int b = 0; b < 16; b++) begin
            pins[b] = dev_oe[b] ? dev_o[b] : host_addr[b];
        end
        // With the strap low the board ties this line high whatever the host drives
        if (!strap) begin
            pins[13] = 1'b1;
        end
    end
endmodule // ext_side_model

//--- bench/tb_top.sv
// Testbench: strap decode, transparent drive gating and register access
`timescale 1ns/1ps

module tb_top;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        strap = 1'b0;
    logic        grant_n = 1'b1;
    logic        strobe_n = 1'b0;
    logic [15:0] host_addr = 16'h0000;
    logic [15:0] ext_addr = 16'h0000;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [15:0] pins, addr_o, addr_oe, host_dec;
    logic [1:0]  clk_sel, boot, code;
    logic        busy, cfg_ok, ack;
    logic [31:0] rdat, rd, exp;
    logic [15:0] l_oe, l_dec;
    logic [1:0]  l_clk, l_boot, r_boot;
    int          err_count = 0;
    int          checks = 0;
    int          cycles = 0;

    always #5 mclk = ~mclk;

    ext_side_model i_ext (.host_addr(host_addr), .strap(strap), .dev_o(addr_o),
        .dev_oe(addr_oe), .pins(pins));

    host_address_bus_port i_dut (.MCLK(mclk), .RST(rst), .ADDR_I(pins), .ADDR_O(addr_o),
        .ADDR_OE(addr_oe), .UPPER_ADDRESS_STRAP(strap), .BUS_GRANT_ACKNOWLEDGE_N(grant_n),
        .IO_ACCESS_STROBE_N(strobe_n), .EXT_RAM_ADDR(ext_addr), .HOST_ADDR(host_dec),
        .CLK_FREQ_SEL(clk_sel), .BOOT_MODE(boot), .RT_BUSY_INIT(busy), .CONFIG_VALID(cfg_ok),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));

    // Large part and RT-only part share all stimulus with the main instance
    host_address_bus_port #(.LARGE_MEMORY(1'b1), .BC_CAPABLE(1'b1)) i_dut_large (
        .MCLK(mclk), .RST(rst), .ADDR_I(pins), .ADDR_O(), .ADDR_OE(l_oe),
        .UPPER_ADDRESS_STRAP(strap), .BUS_GRANT_ACKNOWLEDGE_N(grant_n),
        .IO_ACCESS_STROBE_N(strobe_n), .EXT_RAM_ADDR(ext_addr), .HOST_ADDR(l_dec),
        .CLK_FREQ_SEL(l_clk), .BOOT_MODE(l_boot), .RT_BUSY_INIT(), .CONFIG_VALID(),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(), .WB_ACK_O());

    host_address_bus_port #(.LARGE_MEMORY(1'b0), .BC_CAPABLE(1'b0)) i_dut_rt (
        .MCLK(mclk), .RST(rst), .ADDR_I(pins), .ADDR_O(), .ADDR_OE(),
        .UPPER_ADDRESS_STRAP(strap), .BUS_GRANT_ACKNOWLEDGE_N(grant_n),
        .IO_ACCESS_STROBE_N(strobe_n), .EXT_RAM_ADDR(ext_addr), .HOST_ADDR(),
        .CLK_FREQ_SEL(), .BOOT_MODE(r_boot), .RT_BUSY_INIT(), .CONFIG_VALID(),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(), .WB_ACK_O());

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        checks++;
        if (got !== want) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, want);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Ack is sampled before the edge's own updates land
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            chk(32'h0000_0000, 32'h0000_0001, "no ack");
        end
    endtask

    task automatic boot_up(input logic s, input logic [15:0] a);
        @(posedge mclk);
        rst <= 1'b1;
        strap <= s;
        host_addr <= a;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        settle(3);
    endtask

    // ------------------------------------------------------------
    // Watchdog and tests
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            $display("mismatch at %0t: timeout", $time);
            final_report();
        end
    end

    initial begin
        for (int i = 0; i < 4; i++) begin
            code = i[1:0];
            boot_up(1'b0, {code, 1'b1, code[0], 12'h000});
            chk(addr_oe, 32'h0000_0000, "float");
            chk(clk_sel, code, "clock select");
            exp = code[0] ? addr_port_pkg::BOOT_BC : addr_port_pkg::BOOT_RT_BUSY;
            chk(boot, exp, "boot mode");
            chk(busy, !code[0], "busy start");
            chk(cfg_ok, 32'h0000_0001, "config valid");
            exp = code[0] ? addr_port_pkg::BOOT_IDLE : addr_port_pkg::BOOT_RT_BUSY;
            chk(r_boot, exp, "rt-only boot mode");
            chk(l_boot, addr_port_pkg::BOOT_NONE, "large ignores strap");
            chk(l_clk, 32'h0000_0000, "large no clock select");
            @(posedge mclk);
            host_addr <= 16'h5ABC;
            settle(2);
            chk(clk_sel, code, "strap held");
            chk(host_dec, 32'h0000_0ABC, "decode");
            // Board holds A13 high, so the large part sees it set
            chk(l_dec, 32'h0000_7ABC, "large decode");
        end
        $display("test straps done");
        wb(1'b1, addr_port_pkg::OFS_CONTROL, 32'h0000_0002);
        @(posedge mclk);
        grant_n <= 1'b0;
        strobe_n <= 1'b1;
        ext_addr <= 16'hFFFF;
        settle(3);
        chk(addr_oe, 32'h0000_0000, "buffered");
        wb(1'b0, addr_port_pkg::OFS_CONTROL, 32'h0000_0000);
        chk(rd, 32'h0000_0002, "control read");
        wb(1'b1, addr_port_pkg::OFS_CONTROL, 32'h0000_0003);
        for (int j = 0; j < 4; j++) begin
            @(posedge mclk);
            grant_n <= j[0];
            strobe_n <= j[1];
            settle(2);
            exp = (j == 2) ? addr_port_pkg::SMALL_DRIVE_MASK : 32'h0000_0000;
            chk(addr_oe, exp, "drive gate");
            // Drive value follows the masked memory address even while floating
            chk(addr_o, addr_port_pkg::SMALL_DRIVE_MASK, "drive value");
            exp = (j == 2) ? addr_port_pkg::FULL_MASK : 32'h0000_0000;
            chk(l_oe, exp, "large drive gate");
        end
        wb(1'b0, 8'h10, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "unmapped read");
        wb(1'b0, addr_port_pkg::OFS_HOST_ADDR, 32'h0000_0000);
        chk(rd, 32'h0000_0ABC, "host address read");
        wb(1'b0, addr_port_pkg::OFS_STATUS, 32'h0000_0000);
        exp = (32'h0000_0003 << addr_port_pkg::ST_CLK_SEL_LO)
            | (32'(addr_port_pkg::BOOT_BC) << addr_port_pkg::ST_BOOT_LO);
        chk(rd, exp, "status strap low");
        wb(1'b0, addr_port_pkg::OFS_EXT_ADDR, 32'h0000_0000);
        chk(rd, addr_port_pkg::SMALL_DRIVE_MASK, "external address read");
        $display("test transparent done");
        boot_up(1'b1, 16'hF123);
        chk(boot, addr_port_pkg::BOOT_NONE, "no alternate pins");
        chk(clk_sel, 32'h0000_0000, "no clock select");
        chk(host_dec, 32'h0000_0123, "decode strap high");
        chk(l_dec, 32'h0000_F123, "large decode strap high");
        wb(1'b1, addr_port_pkg::OFS_CONTROL, 32'h0000_0003);
        @(posedge mclk);
        grant_n <= 1'b0;
        strobe_n <= 1'b1;
        settle(2);
        chk(addr_oe, addr_port_pkg::FULL_MASK, "upper lines drive");
        wb(1'b0, addr_port_pkg::OFS_STATUS, 32'h0000_0000);
        exp = (32'h0000_0001 << addr_port_pkg::ST_STRAP)
            | (32'h0000_0003 << addr_port_pkg::ST_BOOT_LO)
            | (32'h0000_0001 << addr_port_pkg::ST_DRIVING);
        chk(rd, exp, "status strap high");
        $display("test strap high done");
        final_report();
    end
endmodule // tb_top
